// ==== rtl/rdw_core.sv ====
// relay output dual watchdog control core with axi4-lite registers
// What this block does
// RULE1: factory defaults address 01 type 40 9600
// RULE2: modbus variant defaults to modbus protocol
// RULE3: recovery mode: address 00, 9600, no checksum
// RULE4: recovery mode only from strap at power-up
// RULE5: keep settings stored, readable in recovery
// RULE6: baud or checksum change only in recovery
// RULE7: reset drives power-on value if flag clear
// RULE8: host timeout drives safe value, status 04
// RULE9: timeout flag set: ignore outputs, reply !
// RULE10: timeout flag sticky, only clear command clears
// RULE11: flag clear: apply outputs, reply >
// RULE12: module watchdog resets stalled module
// RULE13: reset flag set on reset, read clears
// RULE14: latch input low pulses between reads
// RULE15: baud code 03 to 0A decoded
// RULE16: format bit 7 selects counter edge
// RULE17: format bit 6 enables checksum
// RULE18: host writes reserved format bits zero
// RULE19: io reply: outputs, inputs, trailing 00
// RULE20: single channel 0..3, data 00 or 01
// RULE21: reset reply 1 after reset, else 0
// RULE22: host watchdog restarts on each valid command
// RULE23: new settings take effect after power-on
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`include "rdw_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module rdw_core #(
    parameter int unsigned MWDT_CYC = `RDW_MWDT_CYC,
    parameter int unsigned TICK_CYC = `RDW_HWDT_TICK_CYC,
    parameter bit          MODBUS   = 1'b0
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic        por_pulse,
    input  wire logic        init_strap_n,
    input  wire logic [3:0]  input_bits,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [3:0]       output_bits,
    output logic             init_mode,
    output logic             modbus_mode,
    output logic             chk_enable,
    output logic             count_rising,
    output logic [7:0]       act_addr,
    output logic [7:0]       act_baud,
    output logic             mod_reset
);
    // ----------------------------------------------------------------
    // axi write/read handshake
    // ----------------------------------------------------------------
    logic        aw_q, w_q, ar_q;
    logic [7:0]  awa_q, ara_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        do_wr, do_rd;
    assign do_wr = clk_en && aw_q && w_q && !s_axi_bvalid;
    assign do_rd = clk_en && ar_q && !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (clk_en) begin
            s_axi_awready <= !aw_q && !s_axi_awready;
            s_axi_wready <= !w_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awa_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awa_q[7:5] == 3'b000 && awa_q[1:0] == 2'b00)
                             ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_q <= 1'b0;
            ara_q <= 8'h00;
            s_axi_arready <= 1'b0;
        end else if (clk_en) begin
            s_axi_arready <= !ar_q && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                ar_q <= 1'b1;
                ara_q <= s_axi_araddr;
                s_axi_arready <= 1'b0;
            end
            if (do_rd) begin
                ar_q <= 1'b0;
            end
        end
    end
    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    logic wr_ctrl, wr_cmd, wr_cfg, wr_vals, wr_wdog;
    assign wr_ctrl = do_wr && awa_q == `RDW_CTRL_OFS && ws_q[0];
    assign wr_cmd  = do_wr && awa_q == `RDW_CMD_OFS && ws_q[0];
    assign wr_cfg  = do_wr && awa_q == `RDW_CFG_OFS && ws_q == 4'hF;
    assign wr_vals = do_wr && awa_q == `RDW_VALS_OFS && ws_q[0];
    assign wr_wdog = do_wr && awa_q == `RDW_WDOG_OFS && ws_q[1:0] == 2'h3;
    logic [7:0] cmd_code, cmd_arg;
    assign cmd_code = wd_q[7:0];
    assign cmd_arg  = wd_q[15:8];
    logic is_out_cmd, cmd_valid;
    assign is_out_cmd = wr_cmd && (cmd_code == `RDW_CMD_DO_MULTI ||
                                   cmd_code == `RDW_CMD_DO_SINGLE);
    assign cmd_valid = wr_cmd && cmd_code >= `RDW_CMD_STATUS &&
                       cmd_code <= `RDW_CMD_SYNC_SMP;
    // ----------------------------------------------------------------
    // reset sources: power-on and module watchdog
    // ----------------------------------------------------------------
    logic [31:0] mwdt_q;
    logic        kick;
    assign kick = wr_ctrl && wd_q[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mwdt_q <= 32'h0000_0000;
            mod_reset <= 1'b0;
        end else if (clk_en) begin
            mod_reset <= 1'b0;
            if (kick || por_pulse) begin
                mwdt_q <= 32'h0000_0000;
            end else if (mwdt_q >= MWDT_CYC - 1) begin
                mwdt_q <= 32'h0000_0000;
                mod_reset <= 1'b1; // RULE12
            end else begin
                mwdt_q <= mwdt_q + 32'h0000_0001;
            end
        end
    end
    logic any_rst;
    assign any_rst = por_pulse || mod_reset;
    // ----------------------------------------------------------------
    // nonvolatile configuration and power-on capture
    // ----------------------------------------------------------------
    logic [7:0] nv_addr_q, nv_baud_q, nv_fmt_q, nv_type_q;
    logic [7:0] pwron_q, safe_q, fmt_act_q;
    logic [15:0] hwdt_int_q;
    logic hwdt_en_q, to_flag_q;
    logic cfg_ok;
    assign cfg_ok = wr_cfg && wd_q[23:16] == `RDW_DEF_TYPE &&
        (init_mode || (wd_q[15:8] == nv_baud_q && // RULE6
         wd_q[`RDW_FMT_CHK_BIT] == nv_fmt_q[`RDW_FMT_CHK_BIT])) &&
        wd_q[15:8] >= `RDW_BAUD_MIN && wd_q[15:8] <= `RDW_BAUD_MAX; // RULE15
    // nonvolatile state survives both reset sources, only aresetn loads it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nv_addr_q <= `RDW_DEF_ADDR; // RULE1
            nv_type_q <= `RDW_DEF_TYPE;
            nv_baud_q <= `RDW_DEF_BAUD;
            nv_fmt_q <= `RDW_DEF_FMT;
            pwron_q <= 8'h00;
            safe_q <= 8'h00;
            hwdt_int_q <= 16'h0000;
            hwdt_en_q <= 1'b0;
        end else if (clk_en) begin
            if (cfg_ok) begin
                nv_addr_q <= wd_q[31:24]; // RULE5
                nv_baud_q <= wd_q[15:8];
                nv_fmt_q <= wd_q[7:0] & ~`RDW_FMT_RSVD_MASK; // RULE18
            end
            if (wr_vals) begin
                pwron_q <= {4'h0, wd_q[3:0]};
                safe_q <= {4'h0, wd_q[11:8]};
            end
            if (wr_wdog) begin
                hwdt_int_q <= wd_q[15:0];
                hwdt_en_q <= wd_q[16];
            end
        end
    end
    // settings latched only at power-on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_mode <= 1'b0;
            act_addr <= `RDW_DEF_ADDR;
            act_baud <= `RDW_DEF_BAUD;
            fmt_act_q <= `RDW_DEF_FMT;
            modbus_mode <= 1'b0;
        end else if (clk_en && por_pulse) begin
            init_mode <= !init_strap_n; // RULE4
            modbus_mode <= MODBUS && init_strap_n; // RULE2
            act_addr <= !init_strap_n ? `RDW_INIT_ADDR : nv_addr_q; // RULE3
            act_baud <= !init_strap_n ? `RDW_DEF_BAUD : nv_baud_q; // RULE23
            fmt_act_q <= !init_strap_n ?
                         (nv_fmt_q & 8'hBF) : nv_fmt_q;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chk_enable <= 1'b0;
            count_rising <= 1'b0;
        end else if (clk_en) begin
            chk_enable <= fmt_act_q[`RDW_FMT_CHK_BIT]; // RULE17
            count_rising <= fmt_act_q[`RDW_FMT_EDGE_BIT]; // RULE16
        end
    end
    // ----------------------------------------------------------------
    // host watchdog
    // ----------------------------------------------------------------
    logic [31:0] tick_q;
    logic [15:0] hcnt_q;
    logic        tick, expire;
    assign tick = tick_q >= TICK_CYC - 1;
    assign expire = hwdt_en_q && tick && hcnt_q + 16'h0001 >= hwdt_int_q &&
                    hwdt_int_q != 16'h0000;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_q <= 32'h0000_0000;
            hcnt_q <= 16'h0000;
        end else if (clk_en) begin
            if (cmd_valid || any_rst) begin
                tick_q <= 32'h0000_0000; // RULE22
                hcnt_q <= 16'h0000;
            end else if (tick) begin
                tick_q <= 32'h0000_0000;
                hcnt_q <= expire ? 16'h0000 : hcnt_q + 16'h0001;
            end else begin
                tick_q <= tick_q + 32'h0000_0001;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            to_flag_q <= 1'b0;
        end else if (clk_en) begin
            if (expire && !cmd_valid) begin
                to_flag_q <= 1'b1; // RULE10
            end else if (wr_cmd && cmd_code == `RDW_CMD_CLR_TO) begin
                to_flag_q <= 1'b0;
            end
        end
    end
    // ----------------------------------------------------------------
    // output selection
    // ----------------------------------------------------------------
    rdw_pkg::rdw_out_e omode_q;
    logic [3:0] cmd_val;
    logic       single_ok;
    assign single_ok = cmd_arg[7:2] == 6'h00 && wd_q[23:17] == 7'h00; // RULE20
    always_comb begin
        cmd_val = output_bits;
        if (cmd_code == `RDW_CMD_DO_MULTI) begin
            cmd_val = wd_q[11:8];
        end else if (single_ok) begin
            cmd_val[cmd_arg[1:0]] = wd_q[16];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_bits <= 4'h0;
            omode_q <= rdw_pkg::RDW_OUT_PWRON;
        end else if (clk_en) begin
            if ((expire && !cmd_valid) || (any_rst && to_flag_q)) begin
                output_bits <= safe_q[3:0]; // RULE8
                omode_q <= rdw_pkg::RDW_OUT_SAFE;
            end else if (any_rst) begin
                output_bits <= pwron_q[3:0]; // RULE7
                omode_q <= rdw_pkg::RDW_OUT_PWRON;
            end else if (is_out_cmd && !to_flag_q) begin
                if (cmd_code == `RDW_CMD_DO_MULTI || single_ok) begin
                    output_bits <= cmd_val; // RULE11
                    omode_q <= rdw_pkg::RDW_OUT_CMD;
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // inputs: latched low, sync sample, reset flag, reply
    // ----------------------------------------------------------------
    logic [3:0] low_q, sync_q;
    logic       sync_new_q, rst_flag_q;
    logic [31:0] reply_q;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_low
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    low_q[gi] <= 1'b0;
                end else if (clk_en) begin
                    if (!input_bits[gi]) begin
                        low_q[gi] <= 1'b1; // RULE14
                    end else if (wr_cmd &&
                                 cmd_code == `RDW_CMD_LATCH_LOW) begin
                        low_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_flag_q <= 1'b1;
            sync_q <= 4'h0;
            sync_new_q <= 1'b0;
        end else if (clk_en) begin
            if (any_rst) begin
                rst_flag_q <= 1'b1; // RULE13
            end else if (wr_cmd && cmd_code == `RDW_CMD_RST_FLAG) begin
                rst_flag_q <= 1'b0;
            end
            if (wr_cmd && cmd_code == `RDW_CMD_SYNC_SMP) begin
                sync_q <= input_bits;
                sync_new_q <= 1'b1;
            end else if (wr_cmd && cmd_code == `RDW_CMD_SYNC_RD) begin
                sync_new_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reply_q <= 32'h0000_0000;
        end else if (clk_en && wr_cmd) begin
            case (cmd_code)
                `RDW_CMD_STATUS:
                    reply_q <= {24'h00_003E, to_flag_q ? `RDW_STAT_TIMEOUT
                                : `RDW_STAT_NORMAL}; // RULE8
                `RDW_CMD_RST_FLAG:
                    reply_q <= {24'h00_003E, 7'h00, rst_flag_q}; // RULE21
                `RDW_CMD_IO_STATE:
                    reply_q <= {4'h0, output_bits, 4'h0, input_bits,
                                8'h00, `RDW_RSP_OK}; // RULE19
                `RDW_CMD_LATCH_LOW:
                    reply_q <= {4'h0, output_bits, 4'h0, low_q,
                                8'h00, `RDW_RSP_OK};
                `RDW_CMD_SYNC_RD:
                    reply_q <= sync_new_q ? {4'h0, output_bits, 4'h0, sync_q,
                               7'h00, 1'b1, `RDW_RSP_OK} :
                               {24'h00_0000, `RDW_RSP_OK};
                `RDW_CMD_DO_MULTI, `RDW_CMD_DO_SINGLE:
                    reply_q <= {24'h00_0000, to_flag_q ? `RDW_RSP_IGNORE // RULE9
                                : (cmd_code == `RDW_CMD_DO_MULTI || single_ok)
                                ? `RDW_RSP_OK : `RDW_RSP_INVALID};
                `RDW_CMD_READ_CFG:
                    reply_q <= {nv_type_q, nv_baud_q, nv_fmt_q,
                                `RDW_RSP_OK}; // RULE5
                `RDW_CMD_SET_CFG, `RDW_CMD_CLR_TO, `RDW_CMD_SYNC_SMP:
                    reply_q <= {24'h00_0000, `RDW_RSP_OK};
                default:
                    reply_q <= {24'h00_0000, `RDW_RSP_INVALID};
            endcase
        end else if (clk_en && wr_cfg) begin
            reply_q <= {24'h00_0000, cfg_ok ? `RDW_RSP_OK : `RDW_RSP_INVALID};
        end
    end
    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (clk_en) begin
            if (do_rd) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (ara_q)
                    `RDW_CTRL_OFS:   s_axi_rdata <= 32'h0000_0000;
                    `RDW_STATUS_OFS: s_axi_rdata <= {21'h00_0000, omode_q,
                        modbus_mode, init_mode, sync_new_q, rst_flag_q,
                        to_flag_q, 3'h0};
                    `RDW_CMD_OFS:    s_axi_rdata <= reply_q;
                    `RDW_CFG_OFS:    s_axi_rdata <= {nv_addr_q, nv_type_q,
                                                     nv_baud_q, nv_fmt_q};
                    `RDW_VALS_OFS:   s_axi_rdata <= {16'h0000, safe_q, pwron_q};
                    `RDW_IO_OFS:     s_axi_rdata <= {20'h0_0000, low_q,
                                                     output_bits, input_bits};
                    `RDW_WDOG_OFS:   s_axi_rdata <= {15'h0000, hwdt_en_q,
                                                     hwdt_int_q};
                    `RDW_NVCFG_OFS:  s_axi_rdata <= {act_addr, act_baud,
                                                     fmt_act_q, 8'h00};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_safe_on_expire;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && expire && !cmd_valid) |=> output_bits == $past(safe_q[3:0]);
    endproperty
    a_safe_on_expire: assert property (p_safe_on_expire) // RULE8
        else $error("safe value not applied");
    property p_ignore_when_to;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && is_out_cmd && to_flag_q && !any_rst && !expire)
        |=> $stable(output_bits);
    endproperty
    a_ignore_when_to: assert property (p_ignore_when_to) // RULE9
        else $error("output changed while timed out");
    property p_flag_sticky;
        @(posedge aclk) disable iff (!aresetn)
        (to_flag_q && !(wr_cmd && cmd_code == `RDW_CMD_CLR_TO)) |=> to_flag_q;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // RULE10
        else $error("timeout flag lost");
    property p_pwron;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && any_rst && !to_flag_q && !expire)
        |=> output_bits == $past(pwron_q[3:0]);
    endproperty
    a_pwron: assert property (p_pwron) // RULE7
        else $error("power-on value not applied");
    property p_rst_flag;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && any_rst) |=> rst_flag_q;
    endproperty
    a_rst_flag: assert property (p_rst_flag) // RULE13
        else $error("reset flag not set");
    property p_init_addr;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && por_pulse && !init_strap_n) |=> act_addr == 8'h00 && init_mode;
    endproperty
    a_init_addr: assert property (p_init_addr) // RULE3
        else $error("recovery address wrong");
    property p_latch_low;
        @(posedge aclk) disable iff (!aresetn)
        (clk_en && input_bits != 4'hF) |=> (low_q & ~$past(input_bits)) ==
                                            ~$past(input_bits);
    endproperty
    a_latch_low: assert property (p_latch_low) // RULE14
        else $error("low pulse not latched");
    property p_mwdt;
        @(posedge aclk) disable iff (!aresetn)
        mod_reset |-> $past(mwdt_q) >= MWDT_CYC - 1;
    endproperty
    a_mwdt: assert property (p_mwdt) // RULE12
        else $error("module reset without stall");
endmodule : rdw_core
`default_nettype wire

// ==== rtl/rdw_defines.svh ====
// offsets, field positions, reset values and timing counts
`ifndef RDW_DEFINES_SVH
`define RDW_DEFINES_SVH
// register byte offsets
`define RDW_CTRL_OFS       8'h00
`define RDW_STATUS_OFS     8'h04
`define RDW_CMD_OFS        8'h08
`define RDW_CFG_OFS        8'h0C
`define RDW_VALS_OFS       8'h10
`define RDW_IO_OFS         8'h14
`define RDW_WDOG_OFS       8'h18
`define RDW_NVCFG_OFS      8'h1C
// command codes written to the command register
`define RDW_CMD_STATUS     8'h01
`define RDW_CMD_CLR_TO     8'h02
`define RDW_CMD_RST_FLAG   8'h03
`define RDW_CMD_IO_STATE   8'h04
`define RDW_CMD_LATCH_LOW  8'h05
`define RDW_CMD_SYNC_RD    8'h06
`define RDW_CMD_DO_MULTI   8'h07
`define RDW_CMD_DO_SINGLE  8'h08
`define RDW_CMD_SET_CFG    8'h09
`define RDW_CMD_READ_CFG   8'h0A
`define RDW_CMD_SYNC_SMP   8'h0B
// reply codes
`define RDW_RSP_OK         8'h3E
`define RDW_RSP_IGNORE     8'h21
`define RDW_RSP_INVALID    8'h3F
// defaults
`define RDW_DEF_ADDR       8'h01
`define RDW_DEF_TYPE       8'h40
`define RDW_DEF_BAUD       8'h06
`define RDW_DEF_FMT        8'h00
`define RDW_INIT_ADDR      8'h00
`define RDW_STAT_TIMEOUT   8'h04
`define RDW_STAT_NORMAL    8'h00
// format byte fields
`define RDW_FMT_EDGE_BIT   7
`define RDW_FMT_CHK_BIT    6
`define RDW_FMT_RSVD_MASK  8'h3F
// baud code range
`define RDW_BAUD_MIN       8'h03
`define RDW_BAUD_MAX       8'h0A
// module watchdog: stall time in us, derived cycles at 100 MHz
`define RDW_CLK_MHZ        100
`define RDW_MWDT_US        1000
`define RDW_MWDT_CYC       (`RDW_MWDT_US * `RDW_CLK_MHZ)
// host watchdog tick: 100 ms units
`define RDW_HWDT_TICK_US   100000
`define RDW_HWDT_TICK_CYC  (`RDW_HWDT_TICK_US * `RDW_CLK_MHZ)
`endif

// ==== rtl/rdw_pkg.sv ====
// types for the relay output dual watchdog block
package rdw_pkg;
    typedef enum logic [2:0] {
        RDW_OUT_PWRON = 3'b001,
        RDW_OUT_SAFE  = 3'b010,
        RDW_OUT_CMD   = 3'b100
    } rdw_out_e;
    typedef logic [7:0] rdw_byte_t;
endpackage : rdw_pkg

// ==== testbench/rdw_host.sv ====
// axi4-lite host model issuing register accesses
`timescale 1ns/100ps
`default_nettype none
module rdw_host (
    input wire logic aclk
);
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, awready;
    logic        arvalid = 1'b0, rready = 1'b0, wready, bvalid;
    logic        arready, rvalid;
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk) {awaddr, wdata} <= {a, v};
        {awvalid, wvalid, bready} <= 3'b111;
        do @(posedge aclk) begin
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] r);
        @(posedge aclk) araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge aclk) if (arready) arvalid <= 1'b0; while (!rvalid);
        {v, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask : rd
endmodule : rdw_host
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the relay output dual watchdog core
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin \
    failures++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
    logic        aclk = 1'b0, aresetn = 1'b0, por_pulse = 1'b0;
    logic        init_strap_n = 1'b1, init_mode, chk_enable, modbus_mode;
    logic        count_rising, mod_reset;
    logic [3:0]  input_bits = 4'h0, output_bits;
    logic [7:0]  act_addr, act_baud;
    logic [31:0] d;
    logic [1:0]  r;
    int          failures = 0, comparisons = 0;
    logic [35:0] rows [3] = '{36'hA07A, 36'h1088, 36'h10_208C};
    always #5 aclk = ~aclk;
    rdw_host h (.aclk);
    rdw_core #(.MWDT_CYC(2000), .TICK_CYC(10)) u_rdw_core (
        .aclk, .aresetn, .clk_en(1'b1), .por_pulse, .init_strap_n,
        .input_bits, .s_axi_awaddr(h.awaddr), .s_axi_awvalid(h.awvalid),
        .s_axi_awready(h.awready), .s_axi_wdata(h.wdata),
        .s_axi_wstrb(h.wstrb), .s_axi_wvalid(h.wvalid),
        .s_axi_wready(h.wready), .s_axi_bresp(h.bresp),
        .s_axi_bvalid(h.bvalid), .s_axi_bready(h.bready),
        .s_axi_araddr(h.araddr), .s_axi_arvalid(h.arvalid),
        .s_axi_arready(h.arready), .s_axi_rdata(h.rdata),
        .s_axi_rresp(h.rresp), .s_axi_rvalid(h.rvalid),
        .s_axi_rready(h.rready), .output_bits, .init_mode, .modbus_mode,
        .chk_enable, .count_rising, .act_addr, .act_baud, .mod_reset
    );
    task automatic cmd(input logic [31:0] c, m, e);
        h.wr(8'h08, c);
        h.rd(8'h08, d, r);
        `CHK("reply", d & m, e)
    endtask : cmd
    task automatic cfg(input logic [31:0] v, input logic [7:0] e);
        h.wr(8'h0C, v);
        h.rd(8'h08, d, r);
        `CHK("config", d[7:0], e)
    endtask : cfg
    task automatic por(input logic s);
        init_strap_n <= s;
        @(posedge aclk) por_pulse <= 1'b1;
        @(posedge aclk) por_pulse <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : por
    task automatic print_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("defaults", {act_addr, act_baud, modbus_mode}, 17'h20C)
        cmd(32'h3, 32'h1, 32'h1);
        cmd(32'h3, 32'h1, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            cmd(rows[i][35:4], 32'hFF, 32'h3E);
            `CHK("outputs", output_bits, rows[i][3:0])
        end
        input_bits <= 4'hF;
        cmd(32'h5, 32'h0, 32'h0);
        input_bits <= 4'hD;
        repeat (2) @(posedge aclk);
        input_bits <= 4'hF;
        cmd(32'h5, 32'h0F0F_FF00, 32'h0C02_0000);
        cmd(32'h4, 32'h0F0F_FF00, 32'h0C0F_0000);
        cmd(32'hB, 32'h0, 32'h0);
        cmd(32'h6, 32'h0F0F_FFFF, 32'h0C0F_013E);
        cmd(32'h6, 32'h100, 32'h0);
        h.rd(8'h20, d, r);
        `CHK("unmapped", r, 2'b10)
        h.wr(8'h20, 32'h0);
        `CHK("bresp", h.bresp, 2'b10)
        h.wr(8'h10, 32'h503);
        h.wr(8'h18, 32'h1_0001);
        repeat (40) @(posedge aclk);
        cmd(32'h1, 32'hFF, 32'h04);
        cmd(32'hF07, 32'hFF, 32'h21);
        por(1'b0);
        `CHK("safe", output_bits, 4'h5)
        `CHK("init", {init_mode, chk_enable, act_addr, act_baud}, 18'h2_0006)
        h.wr(8'h18, 32'h0);
        cmd(32'h2, 32'hFF, 32'h3E);
        por(1'b1);
        `CHK("power on", {init_mode, output_bits}, 5'h03)
        $display("host watchdog test done");
        cfg(32'h0240_0740, 8'h3F);
        cfg(32'h0240_0680, 8'h3E);
        `CHK("active", act_addr, 8'h01)
        cmd(32'hA, 32'hFFFF_FFFF, 32'h4006_803E);
        por(1'b0);
        cfg(32'h0240_0BC0, 8'h3F);
        cfg(32'h0240_0AC0, 8'h3E);
        por(1'b1);
        `CHK("applied", {act_addr, act_baud}, 16'h020A)
        `CHK("format", {chk_enable, count_rising}, 2'b11)
        cmd(32'h3, 32'h1, 32'h1);
        $display("config test done");
        for (int n = 0; n < 3000 && !mod_reset; n++) @(posedge aclk);
        `CHK("module reset", mod_reset, 1'b1)
        cmd(32'h3, 32'h1, 32'h1);
        $display("module watchdog test done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
